// >>> guard_consts.svh
// Functional notes
// - four protection bits live in an extra security byte at 8000H, reached through the two address registers, and software may set or clear them.
// - the protect flag is 1 when three or four protection bits are set and 0 when two or more are cleared.
// - while the protect flag is 1, EEPROM access works in one mode only, and external execution by pin or by passing 4K is treated alike.
// - block erase is enabled only when the protect flag is 1 and the CPU executes externally.
// - a finished block erase has cleared all 256 data bytes, the protection bits and the protect flag, and shows it by clearing write pending.
// - a byte-mode write to the security byte updates the protect flag, except when the flag is 1 and the CPU executes externally.
// - external access mode is chosen only by the pin being low at reset and never switches to internal during a code table read.
// - code table reads of the lower 4K succeed only while executing from internal memory, never returning internal ROM to external code.
// - with the mask ROM protection bit set and execution past 4K, any internal ROM access from external code is refused.
// - no mode copies ROM contents to a port, and test access never presents internal code at a port.
// - software checks write pending before idle or power-down, and entering either mode aborts any erase or write in progress.
`ifndef GUARD_CONSTS_SVH
`define GUARD_CONSTS_SVH

// register byte offsets
`define OFF_ADDR_HIGH   8'h00
`define OFF_ADDR_LOW    8'h04
`define OFF_DATA        8'h08
`define OFF_CTRL        8'h0c
`define OFF_STATUS      8'h10
`define OFF_IRQ_STATUS  8'h14
`define OFF_IRQ_MASK    8'h18

// reset values
`define RST_ADDR_HIGH   8'h80
`define RST_ADDR_LOW    8'h00
`define RST_CTRL        8'h00
`define RST_IRQ_MASK    4'h0

// address and command codes
`define SEC_ADDR_HIGH   8'h80
`define SEC_ADDR_LOW    8'h00
`define DATA_PAGE       8'h00
`define CTRL_BLOCK_ERASE 8'h0a
`define ROM_LIMIT       16'h1000

// status bit positions
`define ST_PENDING      0
`define ST_PROTECT      1
`define ST_EXTERNAL     2

// event bit positions
`define EV_DONE         0
`define EV_ABORT        1
`define EV_REFUSED      2
`define EV_ROM_REFUSED  3

// timing
`define CLK_PERIOD_NS   20
`define PROG_TIME_NS    5000000
`define BOOT_CYCLES     2'd2

`endif

// >>> guard_pkg.sv
package guard_pkg;

   typedef enum logic [1:0]
   {
      st_idle = 2'b01,
      st_busy = 2'b10
   } op_state_e;

   typedef enum logic [1:0]
   {
      op_byte   = 2'd0,
      op_secure = 2'd1,
      op_erase  = 2'd2
   } op_kind_e;

   typedef logic [7:0] byte_t;

endpackage

// >>> eeprom_array.sv
`timescale 1ns/1ps

module eeprom_array
   import guard_pkg::*;
(
   // clock
   input  wire logic  pclk,
   // write side
   input  wire logic  we,
   input  wire byte_t waddr,
   input  wire byte_t wdata,
   input  wire logic  clear_all,
   // read side
   input  wire byte_t raddr,
   output byte_t      rdata
);

   byte_t cells [256];

   // non-volatile cells keep no reset
   genvar i;
   generate
      for (i = 0; i < 256; i++)
      begin : g_cell
         always_ff @(posedge pclk)
         begin
            if (clear_all)
               cells[i] <= 8'h00;
            else if (we && waddr == 8'(i))
               cells[i] <= wdata;
         end
      end
   endgenerate

   always_ff @(posedge pclk)
   begin
      rdata <= cells[raddr];
   end

endmodule

// >>> eeprom_rom_security_guard.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "guard_consts.svh"

module eeprom_rom_security_guard
   import guard_pkg::*;
#(
   parameter int unsigned prog_cycles = `PROG_TIME_NS / `CLK_PERIOD_NS,
   parameter bit          mask_rom_protect = 1'b1
)
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pin
   input  wire logic        external_access_pin,
   // cpu context
   input  wire logic        exec_upper,
   input  wire logic        idle_enter,
   input  wire logic        powerdown_enter,
   // code table read
   input  wire logic        code_table_read,
   input  wire logic [15:0] ctr_addr,
   output logic             ctr_ack,
   output logic             ctr_allow,
   // status
   output logic             write_pending_flag,
   output logic             protect_active_flag,
   output logic             irq
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   op_state_e   state;
   op_state_e   next_state;
   op_kind_e    kind;
   op_kind_e    next_kind;
   byte_t       addr_high;
   byte_t       next_addr_high;
   byte_t       addr_low;
   byte_t       next_addr_low;
   byte_t       ctrl;
   byte_t       next_ctrl;
   byte_t       pend_data;
   byte_t       next_pend_data;
   byte_t       pend_addr;
   byte_t       next_pend_addr;
   logic [3:0]  prot_bits;
   logic [3:0]  next_prot_bits;
   logic        next_protect;
   logic        next_pending;
   logic [23:0] count;
   logic [23:0] next_count;
   logic [3:0]  irq_status;
   logic [3:0]  next_irq_status;
   logic [3:0]  irq_mask;
   logic [3:0]  next_irq_mask;
   logic        next_irq;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        next_ctr_ack;
   logic        next_ctr_allow;
   logic [1:0]  boot;
   logic [1:0]  next_boot;
   logic        ext_mode;
   logic        next_ext_mode;
   logic        ea_meta;
   logic        ea_sync;
   logic        mem_we;
   logic        mem_clear;
   byte_t       mem_rdata;
   logic        sec_sel;
   logic        page_sel;
   logic        ext_now;
   logic        locked;
   logic        acc_write;
   logic        acc_setup;
   logic [3:0]  events;
   logic        lower_rom;
   logic        rom_ok;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic majority(input logic [3:0] b);
      logic [2:0] n;
      n = 3'(b[0]) + 3'(b[1]) + 3'(b[2]) + 3'(b[3]);
      return n >= 3'd3;
   endfunction
   localparam logic [23:0] prog_last = 24'(prog_cycles - 1);

   // -----------------------------------------------------------------
   // pin synchroniser
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ea_meta <= 1'b1;
         ea_sync <= 1'b1;
      end
      else
      begin
         ea_meta <= external_access_pin;
         ea_sync <= ea_meta;
      end
   end

   // -----------------------------------------------------------------
   // eeprom cells
   // -----------------------------------------------------------------
   eeprom_array u_array
   (
      .pclk      (pclk),
      .we        (mem_we),
      .waddr     (pend_addr),
      .wdata     (pend_data),
      .clear_all (mem_clear),
      .raddr     (next_addr_low),
      .rdata     (mem_rdata)
   );

   // -----------------------------------------------------------------
   // next values
   // -----------------------------------------------------------------
   always_comb
   begin
      next_state      = state;
      next_kind       = kind;
      next_addr_high  = addr_high;
      next_addr_low   = addr_low;
      next_ctrl       = ctrl;
      next_pend_data  = pend_data;
      next_pend_addr  = pend_addr;
      next_prot_bits  = prot_bits;
      next_protect    = protect_active_flag;
      next_pending    = write_pending_flag;
      next_count      = count;
      next_irq_mask   = irq_mask;
      next_boot       = boot;
      next_ext_mode   = ext_mode;
      next_prdata     = 32'h0000_0000;
      next_pready     = 1'b0;
      next_pslverr    = 1'b0;
      next_ctr_ack    = 1'b0;
      next_ctr_allow  = ctr_allow;
      mem_we          = 1'b0;
      mem_clear       = 1'b0;
      events          = 4'h0;

      sec_sel   = addr_high == `SEC_ADDR_HIGH && addr_low == `SEC_ADDR_LOW;
      page_sel  = addr_high == `DATA_PAGE;
      ext_now   = ext_mode | exec_upper;
      locked    = protect_active_flag & ext_now;
      acc_setup = psel & ~penable;
      acc_write = psel & penable & pready & pwrite;

      // strap capture once the synchroniser has settled
      if (boot != 2'd3)
      begin
         next_boot = boot + 2'd1;
         if (boot == `BOOT_CYCLES)
         begin
            next_ext_mode = ~ea_sync;
            next_protect  = majority(prot_bits);
         end
      end

      // register reads, answered one cycle after setup
      if (acc_setup)
      begin
         next_pready = 1'b1;
         if (!pwrite)
         begin
            unique case (paddr)
               `OFF_ADDR_HIGH:  next_prdata = {24'h0, addr_high};
               `OFF_ADDR_LOW:   next_prdata = {24'h0, addr_low};
               `OFF_CTRL:       next_prdata = {24'h0, ctrl};
               `OFF_IRQ_STATUS: next_prdata = {28'h0, irq_status};
               `OFF_IRQ_MASK:   next_prdata = {28'h0, irq_mask};
               `OFF_STATUS:
               begin
                  next_prdata[`ST_PENDING]  = write_pending_flag;
                  next_prdata[`ST_PROTECT]  = protect_active_flag;
                  next_prdata[`ST_EXTERNAL] = ext_mode;
               end
               `OFF_DATA:
               begin
                  if (locked)
                     events[`EV_REFUSED] = 1'b1;
                  else if (sec_sel)
                     next_prdata = {28'h0, prot_bits};
                  else if (page_sel)
                     next_prdata = {24'h0, mem_rdata};
               end
               default:         next_pslverr = 1'b1;
            endcase
         end
         else if (paddr != `OFF_ADDR_HIGH && paddr != `OFF_ADDR_LOW &&
                  paddr != `OFF_DATA && paddr != `OFF_CTRL &&
                  paddr != `OFF_STATUS && paddr != `OFF_IRQ_STATUS &&
                  paddr != `OFF_IRQ_MASK)
            next_pslverr = 1'b1;
      end

      // register writes take effect at the access edge
      if (acc_write)
      begin
         if (paddr == `OFF_ADDR_HIGH)
            next_addr_high = pwdata[7:0];
         if (paddr == `OFF_ADDR_LOW)
            next_addr_low = pwdata[7:0];
         if (paddr == `OFF_CTRL)
            next_ctrl = pwdata[7:0];
         if (paddr == `OFF_IRQ_MASK)
            next_irq_mask = pwdata[3:0];
         if (paddr == `OFF_DATA)
         begin
            if (state == st_busy)
               events[`EV_REFUSED] = 1'b1;
            else if (ctrl == `CTRL_BLOCK_ERASE)
            begin
               // erase only from external code with protection on
               if (sec_sel && locked)
               begin
                  next_state   = st_busy;
                  next_kind    = op_erase;
                  next_pending = 1'b1;
                  next_count   = prog_last;
               end
               else
                  events[`EV_REFUSED] = 1'b1;
            end
            else if (locked)
               events[`EV_REFUSED] = 1'b1;
            else if (sec_sel || page_sel)
            begin
               next_state     = st_busy;
               next_kind      = sec_sel ? op_secure : op_byte;
               next_pend_data = pwdata[7:0];
               next_pend_addr = addr_low;
               next_pending   = 1'b1;
               next_count     = prog_last;
            end
         end
      end

      // programming cycle
      if (state == st_busy)
      begin
         if (idle_enter || powerdown_enter)
         begin
            next_state          = st_idle;
            next_pending        = 1'b0;
            events[`EV_ABORT]   = 1'b1;
         end
         else if (count != 24'h0)
            next_count = count - 24'h1;
         else
         begin
            next_state        = st_idle;
            next_pending      = 1'b0;
            events[`EV_DONE]  = 1'b1;
            unique case (kind)
               op_erase:
               begin
                  mem_clear      = 1'b1;
                  next_prot_bits = 4'h0;
                  next_protect   = 1'b0;
               end
               op_secure:
               begin
                  next_prot_bits = pend_data[3:0];
                  next_protect   = majority(pend_data[3:0]);
               end
               op_byte:
                  mem_we = 1'b1;
               default:
                  mem_we = 1'b0;
            endcase
         end
      end

      // code table reads: grant only, no ROM data passes this block
      lower_rom = ctr_addr < `ROM_LIMIT;
      rom_ok    = ~ext_now &
                  ~(mask_rom_protect & exec_upper);
      if (code_table_read)
      begin
         next_ctr_ack   = 1'b1;
         next_ctr_allow = lower_rom & rom_ok;
         if (lower_rom && !rom_ok)
            events[`EV_ROM_REFUSED] = 1'b1;
      end

      // sticky events: set wins over write-one-clear
      next_irq_status = irq_status;
      if (acc_write && paddr == `OFF_IRQ_STATUS)
         next_irq_status = irq_status & ~pwdata[3:0];
      next_irq_status = next_irq_status | events;
      next_irq        = |(next_irq_status & next_irq_mask);
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state               <= st_idle;
         kind                <= op_byte;
         addr_high           <= `RST_ADDR_HIGH;
         addr_low            <= `RST_ADDR_LOW;
         ctrl                <= `RST_CTRL;
         pend_data           <= 8'h00;
         pend_addr           <= 8'h00;
         prot_bits           <= 4'h0;
         protect_active_flag <= 1'b0;
         write_pending_flag  <= 1'b0;
         count               <= 24'h0;
         irq_status          <= 4'h0;
         irq_mask            <= `RST_IRQ_MASK;
         irq                 <= 1'b0;
         prdata              <= 32'h0000_0000;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
         ctr_ack             <= 1'b0;
         ctr_allow           <= 1'b0;
         boot                <= 2'd0;
         ext_mode            <= 1'b0;
      end
      else
      begin
         state               <= next_state;
         kind                <= next_kind;
         addr_high           <= next_addr_high;
         addr_low            <= next_addr_low;
         ctrl                <= next_ctrl;
         pend_data           <= next_pend_data;
         pend_addr           <= next_pend_addr;
         prot_bits           <= next_prot_bits;
         protect_active_flag <= next_protect;
         write_pending_flag  <= next_pending;
         count               <= next_count;
         irq_status          <= next_irq_status;
         irq_mask            <= next_irq_mask;
         irq                 <= next_irq;
         prdata              <= next_prdata;
         pready              <= next_pready;
         pslverr             <= next_pslverr;
         ctr_ack             <= next_ctr_ack;
         ctr_allow           <= next_ctr_allow;
         boot                <= next_boot;
         ext_mode            <= next_ext_mode;
      end
   end

endmodule

// >>> guard_checker_properties.sv
`timescale 1ns/1ps
`include "guard_consts.svh"

module guard_checker
#(
   parameter int unsigned prog_cycles = 4
)
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   // cpu context
   input wire logic        exec_upper,
   input wire logic        idle_enter,
   input wire logic        powerdown_enter,
   // code table read
   input wire logic        code_table_read,
   input wire logic [15:0] ctr_addr,
   input wire logic        ctr_ack,
   input wire logic        ctr_allow,
   // status
   input wire logic        write_pending_flag,
   input wire logic        protect_active_flag
);
   localparam int pc = prog_cycles;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("no ready after setup");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("error without ready");
   property p_pending_start;
      $rose(write_pending_flag)
         |-> $past(psel) && $past(penable) && $past(pwrite) &&
             $past(paddr) == `OFF_DATA;
   endproperty
   a_pending_start: assert property (p_pending_start)
      else $error("pending without data write");
   property p_pending_bound;
      $rose(write_pending_flag) |-> ##[1:pc] !write_pending_flag;
   endproperty
   a_pending_bound: assert property (p_pending_bound)
      else $error("operation too long");
   property p_pending_full;
      $fell(write_pending_flag) && !$past(idle_enter) &&
         !$past(powerdown_enter)
         |-> $past(write_pending_flag, prog_cycles);
   endproperty
   a_pending_full: assert property (p_pending_full)
      else $error("operation ended early");
   property p_abort;
      (idle_enter || powerdown_enter) && write_pending_flag
         |=> !write_pending_flag;
   endproperty
   a_abort: assert property (p_abort)
      else $error("low power entry did not abort");
   property p_flag_on_done;
      $changed(protect_active_flag) |-> $fell(write_pending_flag);
   endproperty
   a_flag_on_done: assert property (p_flag_on_done)
      else $error("flag changed outside completion");
   property p_ack;
      code_table_read |=> ctr_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("table read not acknowledged");
   property p_no_stray_ack;
      !code_table_read |=> !ctr_ack;
   endproperty
   a_no_stray_ack: assert property (p_no_stray_ack)
      else $error("stray acknowledge");
   property p_upper_refused;
      code_table_read && exec_upper |=> !ctr_allow;
   endproperty
   a_upper_refused: assert property (p_upper_refused)
      else $error("rom read allowed from external code");
   property p_above_rom;
      code_table_read && ctr_addr >= `ROM_LIMIT |=> !ctr_allow;
   endproperty
   a_above_rom: assert property (p_above_rom)
      else $error("allow above rom limit");
endmodule

bind eeprom_rom_security_guard guard_checker #(.prog_cycles(prog_cycles))
   i_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .exec_upper(exec_upper), .idle_enter(idle_enter),
   .powerdown_enter(powerdown_enter), .code_table_read(code_table_read),
   .ctr_addr(ctr_addr), .ctr_ack(ctr_ack), .ctr_allow(ctr_allow),
   .write_pending_flag(write_pending_flag),
   .protect_active_flag(protect_active_flag));

// >>> testbench.sv
`timescale 1ns/1ps
`include "guard_consts.svh"

module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        external_access_pin, exec_upper, idle_enter, irq;
   logic        powerdown_enter, code_table_read, ctr_ack, ctr_allow;
   logic        write_pending_flag, protect_active_flag;
   logic [7:0]  paddr;
   logic [15:0] ctr_addr;
   logic [31:0] pwdata, prdata, rd;
   int          n_fail, checks;

   eeprom_rom_security_guard #(.prog_cycles(4)) i_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_access_pin(external_access_pin),
      .exec_upper(exec_upper), .idle_enter(idle_enter),
      .powerdown_enter(powerdown_enter), .code_table_read(code_table_read),
      .ctr_addr(ctr_addr), .ctr_ack(ctr_ack), .ctr_allow(ctr_allow),
      .write_pending_flag(write_pending_flag),
      .protect_active_flag(protect_active_flag), .irq(irq));

   always #10 pclk = ~pclk;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wait_done;
      do
         @(posedge pclk);
      while (write_pending_flag !== 1'b0);
   endtask

   task automatic ctr(input logic [15:0] a, input logic exp);
      @(posedge pclk);
      code_table_read <= 1'b1;
      ctr_addr        <= a;
      @(posedge pclk);
      code_table_read <= 1'b0;
      @(posedge pclk);
      chkb(ctr_ack, 1'b1);
      chkb(ctr_allow, exp);
   endtask

   task automatic do_reset(input logic pin);
      presetn             <= 1'b0;
      external_access_pin <= pin;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask

   task automatic results;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset;
      rdc(`OFF_ADDR_HIGH, 32'h80);
      rdc(`OFF_ADDR_LOW, 32'h0);
      rdc(`OFF_STATUS, 32'h0);
      chkb(err, 1'b0);
      apb(1'b0, 8'h1c, 32'h0);
      chkb(err, 1'b1);
   endtask

   task automatic t_protect;
      logic [7:0] v [7] = '{8'h03, 8'h07, 8'h09, 8'h0b, 8'hf0, 8'h0e, 8'hff};
      logic       exp;
      foreach (v[i])
      begin
         exp = ($countones(v[i][3:0]) >= 3);
         wr(`OFF_DATA, {24'h0, v[i]});
         wait_done;
         chkb(protect_active_flag, exp);
      end
      rdc(`OFF_DATA, 32'hf);
      rdc(`OFF_STATUS, 32'h2);
   endtask

   task automatic t_irq_erase;
      wr(`OFF_CTRL, 32'ha);
      rdc(`OFF_CTRL, 32'ha);
      wr(`OFF_DATA, 32'h0);
      wait_done;
      chkb(protect_active_flag, 1'b1);
      rdc(`OFF_IRQ_STATUS, 32'h5);
      wr(`OFF_IRQ_MASK, 32'h4);
      rdc(`OFF_IRQ_MASK, 32'h4);
      repeat (2) @(posedge pclk);
      chkb(irq, 1'b1);
      wr(`OFF_IRQ_STATUS, 32'h4);
      repeat (2) @(posedge pclk);
      chkb(irq, 1'b0);
      wr(`OFF_CTRL, 32'h0);
   endtask

   task automatic t_cell;
      wr(`OFF_ADDR_HIGH, 32'h0);
      wr(`OFF_ADDR_LOW, 32'h5);
      wr(`OFF_DATA, 32'h5a);
      wait_done;
      rdc(`OFF_DATA, 32'h5a);
      for (int k = 0; k < 2; k++)
      begin
         wr(`OFF_IRQ_STATUS, 32'hf);
         wr(`OFF_DATA, 32'ha5);
         @(posedge pclk);
         idle_enter      <= (k == 0);
         powerdown_enter <= (k == 1);
         @(posedge pclk);
         idle_enter      <= 1'b0;
         powerdown_enter <= 1'b0;
         @(posedge pclk);
         chkb(write_pending_flag, 1'b0);
         rdc(`OFF_IRQ_STATUS, 32'h2);
         rdc(`OFF_DATA, 32'h5a);
      end
   endtask

   task automatic t_upper;
      exec_upper <= 1'b1;
      wr(`OFF_IRQ_STATUS, 32'hf);
      wr(`OFF_DATA, 32'h11);
      rdc(`OFF_DATA, 32'h0);
      rdc(`OFF_IRQ_STATUS, 32'h4);
      ctr(16'h0100, 1'b0);
      wr(`OFF_ADDR_HIGH, 32'h80);
      wr(`OFF_ADDR_LOW, 32'h0);
      wr(`OFF_CTRL, 32'ha);
      wr(`OFF_DATA, 32'h33);
      wait_done;
      chkb(protect_active_flag, 1'b0);
      rdc(`OFF_DATA, 32'h0);
      exec_upper <= 1'b0;
      wr(`OFF_CTRL, 32'h0);
      wr(`OFF_ADDR_HIGH, 32'h0);
      wr(`OFF_ADDR_LOW, 32'h5);
      rdc(`OFF_DATA, 32'h0);
      ctr(16'h0fff, 1'b1);
      ctr(16'h1000, 1'b0);
   endtask

   task automatic t_ext;
      do_reset(1'b0);
      rdc(`OFF_STATUS, 32'h4);
      ctr(16'h0100, 1'b0);
      wr(`OFF_DATA, 32'hff);
      wait_done;
      chkb(protect_active_flag, 1'b1);
      wr(`OFF_DATA, 32'h0);
      wait_done;
      chkb(protect_active_flag, 1'b1);
      rdc(`OFF_DATA, 32'h0);
      wr(`OFF_CTRL, 32'ha);
      wr(`OFF_DATA, 32'h0);
      wait_done;
      chkb(protect_active_flag, 1'b0);
   endtask

   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      external_access_pin = 1'b1;
      exec_upper = 1'b0;
      idle_enter = 1'b0;
      powerdown_enter = 1'b0;
      code_table_read = 1'b0;
      ctr_addr = 16'h0;
      n_fail = 0;
      checks = 0;
      do_reset(1'b1);
      t_reset;
      t_protect;
      t_irq_erase;
      t_cell;
      t_upper;
      t_ext;
      results;
   end

   initial
   begin
      repeat (4000) @(posedge pclk);
      n_fail++;
      results;
   end
endmodule
